// ### rtl/cfog_pkg.sv
// Purpose: Shared constants and types of the clock fan-out gating block
// Assumes: 125 MHz system clock, serial link at 100 kbit/s
// Notes:   Latch resets give all fourteen outputs enabled
package cfog_pkg;

   localparam int          CFOG_OUTS        = 14;
   localparam logic [6:0]  CFOG_TARGET_ADDR = 7'h69;
   localparam logic [7:0]  CFOG_READ_COUNT  = 8'h03;
   localparam logic [7:0]  CFOG_CMD_CODE    = 8'h00;
   localparam logic [7:0]  CFOG_GATE_LOW_RST  = 8'hcf;
   localparam logic [7:0]  CFOG_GATE_MID_RST  = 8'hf3;
   localparam logic [7:0]  CFOG_GATE_HIGH_RST = 8'hff;
   // Byte index after the address byte where the latches begin
   localparam logic [2:0]  CFOG_FIRST_LATCH = 3'h2;

   // Avalon word offsets of the controller
   localparam logic [1:0]  CFOG_REG_CTRL   = 2'h0;
   localparam logic [1:0]  CFOG_REG_WDATA  = 2'h1;
   localparam logic [1:0]  CFOG_REG_STATUS = 2'h2;
   localparam logic [1:0]  CFOG_REG_RDATA  = 2'h3;
   localparam int          CFOG_CTRL_GO    = 0;
   localparam int          CFOG_CTRL_DIR   = 1;
   localparam int          CFOG_CTRL_NB    = 2;
   localparam int          CFOG_STAT_BUSY  = 0;
   localparam int          CFOG_STAT_NACK  = 1;

   localparam int          CFOG_BIT_NS  = 10000;
   localparam int          CFOG_CLK_NS  = 8;
   localparam int          CFOG_QTR_CYC = (CFOG_BIT_NS + 4 * CFOG_CLK_NS - 1) / (4 * CFOG_CLK_NS);

   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_ADDR = 3'b001,
      DS_WR   = 3'b010,
      DS_ACK  = 3'b011,
      DS_RD   = 3'b100,
      DS_RACK = 3'b101,
      DS_IGN  = 3'b110
   } cfog_dev_state_t;

   typedef enum logic [1:0] {
      HS_IDLE  = 2'b00,
      HS_START = 2'b01,
      HS_BIT   = 2'b10,
      HS_STOP  = 2'b11
   } cfog_host_state_t;

   typedef struct packed {
      logic            scl_s1, scl_s2, scl_d;
      logic            sda_s1, sda_s2, sda_d;
      cfog_dev_state_t st;
      logic [3:0]      cnt;
      logic [2:0]      idx;
      logic [7:0]      sh;
      logic            rw;
      logic            sda_oe;
      logic [7:0]      g0, g1, g2;
   } cfog_dev_t;

   typedef struct packed {
      cfog_host_state_t st;
      logic [1:0]       q;
      logic [9:0]       tick;
      logic [3:0]       bit_i;
      logic [2:0]       idx;
      logic [8:0]       tx;
      logic [8:0]       rx;
      logic             scl_oe, sda_oe;
      logic             busy, nack, dir;
      logic [1:0]       nb;
      logic [23:0]      wdata;
      logic [31:0]      rdata;
      logic             ack;
      logic [31:0]      rd_q;
      logic             sda_s1, sda_s2;
   } cfog_host_t;

endpackage : cfog_pkg

// ### rtl/cfog_if.sv
// Purpose: Two-wire control link between the gating device and its host
// Assumes: Open-drain wires with pull-ups
// Notes:   Wire level is resolved here from the enables
`timescale 1ns/1ps
interface cfog_if;
   logic scl_o;
   logic scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic serial_control_data;

   // Pull-up wins unless some end drives low
   assign scl                 = ~(scl_oe & ~scl_o);
   assign serial_control_data = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev  (input scl, serial_control_data, output dev_sda_o, dev_sda_oe);
   modport host (input scl, serial_control_data,
                 output scl_o, scl_oe, host_sda_o, host_sda_oe);
endinterface : cfog_if

// ### rtl/cfog_dev.sv
// Purpose: Fourteen-output clock fan-out with per-output gating latches
// Assumes: Link slower than i_ref_clk by far; host never stretches
// Notes:   Clock path is combinational; the latches and the link logic are clocked
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Outputs copy buffer input unless gated
// - Test pin low tri-states all outputs
// - One latch bit gates each output
// - Target only, never starts transfers
// - Reads return current latch contents
// - Link runs at 100 kbit/s
// - Bytes go lowest latch first
// - Stop after any byte keeps earlier bytes
// - Command and count bytes are discarded
// - Answers target address 1101001
// - Address LSB: 0 write, 1 read
// - Read starts with count 3
// - Byte 0 gates outputs 0-5
// - Byte 1 gates outputs 6-11
// - Byte 2 top bits gate 12-13
// - Byte 2 reserved bits reset to 1
module cfog_dev
   import cfog_pkg::*;
(
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_ce,
   input  wire logic                 i_buf_in,
   input  wire logic                 i_test_oe_n,
   output logic [CFOG_OUTS-1:0]      o_clk_out,
   output logic [CFOG_OUTS-1:0]      o_clk_oe,
   output logic [7:0]                o_gate_low,
   output logic [7:0]                o_gate_mid,
   output logic [7:0]                o_gate_high,
   output logic                      o_selected,
   cfog_if.dev                       link
);

   localparam cfog_dev_t DEV_RST = '{
      scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
      st: DS_IDLE, cnt: 4'h0, idx: 3'h0, sh: 8'h00, rw: 1'b0, sda_oe: 1'b0,
      g0: CFOG_GATE_LOW_RST, g1: CFOG_GATE_MID_RST, g2: CFOG_GATE_HIGH_RST
   };

   cfog_dev_t dev_reg;
   cfog_dev_t dev_next;

   function automatic logic [CFOG_OUTS-1:0] gate_map(input logic [7:0] b0,
                                                     input logic [7:0] b1,
                                                     input logic [7:0] b2);
      gate_map = {b2[7:6], b1[7:4], b1[1:0], b0[7:6], b0[3:0]};
   endfunction : gate_map

   function automatic logic [7:0] read_byte(input logic [2:0] idx,
                                            input cfog_dev_t   s);
      case (idx)
         3'h0:    read_byte = CFOG_READ_COUNT;
         3'h1:    read_byte = s.g0;
         3'h2:    read_byte = s.g1;
         3'h3:    read_byte = s.g2;
         default: read_byte = 8'hff;
      endcase
   endfunction : read_byte

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] rb;

   // Edges are found only on the second and third stages
   assign scl_rise  = dev_reg.scl_s2 & ~dev_reg.scl_d;
   assign scl_fall  = ~dev_reg.scl_s2 & dev_reg.scl_d;
   assign bus_start = dev_reg.scl_s2 & dev_reg.scl_d & dev_reg.sda_d & ~dev_reg.sda_s2;
   assign bus_stop  = dev_reg.scl_s2 & dev_reg.scl_d & ~dev_reg.sda_d & dev_reg.sda_s2;
   assign rb        = read_byte(dev_reg.idx, dev_reg);

   always_comb begin
      dev_next        = dev_reg;
      dev_next.scl_s1 = link.scl;
      dev_next.scl_s2 = dev_reg.scl_s1;
      dev_next.scl_d  = dev_reg.scl_s2;
      dev_next.sda_s1 = link.serial_control_data;
      dev_next.sda_s2 = dev_reg.sda_s1;
      dev_next.sda_d  = dev_reg.sda_s2;
      if (bus_start) begin
         dev_next.st     = DS_ADDR;
         dev_next.cnt    = 4'h0;
         dev_next.idx    = 3'h0;
         dev_next.sda_oe = 1'b0;
      end else if (bus_stop) begin
         dev_next.st     = DS_IDLE;
         dev_next.sda_oe = 1'b0;
      end else begin
         unique case (dev_reg.st)
            DS_IDLE, DS_IGN: begin
               dev_next.sda_oe = 1'b0;
            end
            DS_ADDR, DS_WR: begin
               if (scl_rise && dev_reg.cnt != 4'h8) begin
                  dev_next.sh  = {dev_reg.sh[6:0], dev_reg.sda_s2};
                  dev_next.cnt = dev_reg.cnt + 4'h1;
               end
               if (scl_fall && dev_reg.cnt == 4'h8) begin
                  dev_next.cnt = 4'h0;
                  if (dev_reg.st == DS_ADDR) begin
                     if (dev_reg.sh[7:1] == CFOG_TARGET_ADDR) begin
                        dev_next.rw     = dev_reg.sh[0];
                        dev_next.sda_oe = 1'b1;
                        dev_next.st     = DS_ACK;
                     end else begin
                        dev_next.st = DS_IGN;
                     end
                  end else begin
                     case (dev_reg.idx)
                        CFOG_FIRST_LATCH:        dev_next.g0 = dev_reg.sh;
                        CFOG_FIRST_LATCH + 3'h1: dev_next.g1 = dev_reg.sh;
                        CFOG_FIRST_LATCH + 3'h2: dev_next.g2 = dev_reg.sh;
                        default: ;
                     endcase
                     if (dev_reg.idx != 3'h7) begin
                        dev_next.idx = dev_reg.idx + 3'h1;
                     end
                     dev_next.sda_oe = 1'b1;
                     dev_next.st     = DS_ACK;
                  end
               end
            end
            DS_ACK: begin
               if (scl_fall) begin
                  dev_next.sda_oe = 1'b0;
                  dev_next.cnt    = 4'h0;
                  if (dev_reg.rw) begin
                     dev_next.sh     = rb;
                     dev_next.sda_oe = ~rb[7];
                     dev_next.cnt    = 4'h1;
                     dev_next.st     = DS_RD;
                     if (dev_reg.idx != 3'h7) begin
                        dev_next.idx = dev_reg.idx + 3'h1;
                     end
                  end else begin
                     dev_next.st = DS_WR;
                  end
               end
            end
            DS_RD: begin
               if (scl_fall) begin
                  if (dev_reg.cnt == 4'h8) begin
                     dev_next.sda_oe = 1'b0;
                     dev_next.st     = DS_RACK;
                  end else begin
                     dev_next.sda_oe = ~dev_reg.sh[6];
                     dev_next.sh     = {dev_reg.sh[6:0], 1'b0};
                     dev_next.cnt    = dev_reg.cnt + 4'h1;
                  end
               end
            end
            DS_RACK: begin
               // Host nack ends the read; ack goes on to the next byte
               if (scl_rise) begin
                  dev_next.st = dev_reg.sda_s2 ? DS_IGN : DS_ACK;
               end
            end
            default: begin
               dev_next.st     = DS_IDLE;
               dev_next.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         dev_reg <= DEV_RST;
      end else if (i_ce) begin
         dev_reg <= dev_next;
      end
   end

   // Only the data wire is ever driven, and only low
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = dev_reg.sda_oe;

   // Gated copies of the buffer input; gated outputs hold low
   assign o_clk_out = {CFOG_OUTS{i_buf_in}} & gate_map(dev_reg.g0, dev_reg.g1, dev_reg.g2);
   // Test pin releases every output; kept unregistered to stay on the pin path
   assign o_clk_oe  = {CFOG_OUTS{i_test_oe_n}};

   assign o_gate_low  = dev_reg.g0;
   assign o_gate_mid  = dev_reg.g1;
   assign o_gate_high = dev_reg.g2;
   // Sampling relies on the slow link rate
   assign o_selected  = (dev_reg.st != DS_IDLE) && (dev_reg.st != DS_IGN);

endmodule : cfog_dev

// ### rtl/cfog_host.sv
// Purpose: Two-wire host that writes and reads back the gating latches
// Assumes: Avalon-MM slave, one wait cycle per access
// Notes:   Makes the link clock by dividing i_ref_clk; no stretching
`timescale 1ns/1ps
module cfog_host
   import cfog_pkg::*;
#(
   parameter int QTR_CYC = CFOG_QTR_CYC
)(
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic [1:0]   i_avs_address,
   input  wire logic         i_avs_read,
   input  wire logic         i_avs_write,
   input  wire logic [31:0]  i_avs_writedata,
   output logic [31:0]       o_avs_readdata,
   output logic              o_avs_waitrequest,
   output logic              o_busy,
   cfog_if.host              link
);

   localparam logic [9:0] TICK_LOAD = 10'(QTR_CYC - 1);

   cfog_host_t h_reg;
   cfog_host_t h_next;

   // Bytes sent by the host, with ack slot
   function automatic logic [8:0] tx_word(input cfog_host_t s, input logic [2:0] idx);
      logic [7:0] b;
      b = 8'hff;
      if (idx == 3'h0) begin
         b = {CFOG_TARGET_ADDR, s.dir};
      end else if (!s.dir) begin
         case (idx)
            3'h1:    b = CFOG_CMD_CODE;
            3'h2:    b = {6'h00, s.nb};
            3'h3:    b = s.wdata[7:0];
            3'h4:    b = s.wdata[15:8];
            default: b = s.wdata[23:16];
         endcase
      end
      tx_word = {b, 1'b1};
      if (s.dir && idx != 3'h0 && idx != 3'({1'b0, s.nb} + 3'h1)) begin
         tx_word[0] = 1'b0;
      end
   endfunction : tx_word

   function automatic logic [2:0] last_idx(input cfog_host_t s);
      last_idx = s.dir ? 3'({1'b0, s.nb} + 3'h1) : 3'({1'b0, s.nb} + 3'h2);
   endfunction : last_idx

   always_comb begin
      h_next        = h_reg;
      h_next.sda_s1 = link.serial_control_data;
      h_next.sda_s2 = h_reg.sda_s1;
      // Avalon slave: one wait cycle, then answer
      h_next.ack = (i_avs_read | i_avs_write) & ~h_reg.ack;
      if ((i_avs_read | i_avs_write) && !h_reg.ack) begin
         case (i_avs_address)
            CFOG_REG_CTRL:   h_next.rd_q = {28'h0, h_reg.nb, h_reg.dir, 1'b0};
            CFOG_REG_WDATA:  h_next.rd_q = {8'h00, h_reg.wdata};
            CFOG_REG_STATUS: h_next.rd_q = {30'h0, h_reg.nack, h_reg.busy};
            default:         h_next.rd_q = h_reg.rdata;
         endcase
      end
      if (i_avs_write && h_reg.ack && !h_reg.busy) begin
         if (i_avs_address == CFOG_REG_WDATA) begin
            h_next.wdata = i_avs_writedata[23:0];
         end
         if (i_avs_address == CFOG_REG_CTRL) begin
            h_next.dir = i_avs_writedata[CFOG_CTRL_DIR];
            h_next.nb  = i_avs_writedata[CFOG_CTRL_NB +: 2];
            if (i_avs_writedata[CFOG_CTRL_GO]) begin
               h_next.busy = 1'b1;
               h_next.nack = 1'b0;
               h_next.st   = HS_START;
               h_next.q    = 2'h0;
               h_next.tick = TICK_LOAD;
            end
         end
      end
      // Quarter-bit ticks keep the rate at 100 kbit/s
      if (h_reg.st != HS_IDLE) begin
         if (h_reg.tick != 10'h0) begin
            h_next.tick = h_reg.tick - 10'h1;
         end else begin
            h_next.tick = TICK_LOAD;
            h_next.q    = h_reg.q + 2'h1;
            unique case (h_reg.st)
               HS_IDLE: ;
               HS_START: begin
                  if (h_reg.q == 2'h1) h_next.sda_oe = 1'b1;
                  if (h_reg.q == 2'h2) h_next.scl_oe = 1'b1;
                  if (h_reg.q == 2'h3) begin
                     h_next.st    = HS_BIT;
                     h_next.idx   = 3'h0;
                     h_next.bit_i = 4'h0;
                     h_next.tx    = tx_word(h_reg, 3'h0);
                  end
               end
               HS_BIT: begin
                  if (h_reg.q == 2'h0) h_next.sda_oe = ~h_reg.tx[8];
                  if (h_reg.q == 2'h1) h_next.scl_oe = 1'b0;
                  if (h_reg.q == 2'h2) h_next.rx = {h_reg.rx[7:0], h_reg.sda_s2};
                  if (h_reg.q == 2'h3) begin
                     h_next.scl_oe = 1'b1;
                     h_next.tx     = {h_reg.tx[7:0], 1'b1};
                     h_next.bit_i  = h_reg.bit_i + 4'h1;
                     if (h_reg.bit_i == 4'h8) begin
                        h_next.bit_i = 4'h0;
                        if (h_reg.dir && h_reg.idx != 3'h0) begin
                           h_next.rdata[8*(h_reg.idx-3'h1) +: 8] = h_reg.rx[8:1];
                        end
                        // Stop after the last byte or on a nack
                        if ((!h_reg.dir || h_reg.idx == 3'h0) && h_reg.rx[0]) begin
                           h_next.nack = 1'b1;
                           h_next.st   = HS_STOP;
                        end else if (h_reg.idx == last_idx(h_reg)) begin
                           h_next.st = HS_STOP;
                        end else begin
                           h_next.idx = h_reg.idx + 3'h1;
                           h_next.tx  = tx_word(h_reg, 3'(h_reg.idx + 3'h1));
                        end
                     end
                  end
               end
               HS_STOP: begin
                  if (h_reg.q == 2'h0) h_next.sda_oe = 1'b1;
                  if (h_reg.q == 2'h1) h_next.scl_oe = 1'b0;
                  if (h_reg.q == 2'h2) h_next.sda_oe = 1'b0;
                  if (h_reg.q == 2'h3) begin
                     h_next.st   = HS_IDLE;
                     h_next.busy = 1'b0;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         h_reg        <= '0;
         h_reg.st     <= HS_IDLE;
         h_reg.sda_s1 <= 1'b1;
         h_reg.sda_s2 <= 1'b1;
      end else if (i_ce) begin
         h_reg <= h_next;
      end
   end

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~h_reg.ack;
   assign o_avs_readdata    = h_reg.rd_q;
   assign o_busy            = h_reg.busy;
   assign link.scl_o        = 1'b0;
   assign link.scl_oe       = h_reg.scl_oe;
   assign link.host_sda_o   = 1'b0;
   assign link.host_sda_oe  = h_reg.sda_oe;

endmodule : cfog_host

// ### sim/cfog_properties.sv
// Purpose: Wire checks of the two-wire link
// Assumes: Host quarter bit of QTR clock cycles
// Notes:   Frames tracked here from start and clock rises
`timescale 1ns/1ps
module cfog_properties
   import cfog_pkg::*;
#(
   parameter int QTR = 4
)(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic scl,
   input wire logic serial_control_data,
   input wire logic dev_sda_oe
);
   localparam int HALF = 2 * QTR - 1;
   logic       scl_q, sda_q, mine, rd, rise;
   logic [7:0] bitc, sh, hi_c, lo_c;
   assign rise = scl & ~scl_q;
   // Counters saturate so a long idle never wraps into a short phase
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         {mine, rd, bitc, sh, hi_c, lo_c} <= '0;
      end else begin
         scl_q <= scl;
         sda_q <= serial_control_data;
         hi_c <= scl ? hi_c + 8'(hi_c != 8'hff) : 8'h00;
         lo_c <= scl ? 8'h00 : lo_c + 8'(lo_c != 8'hff);
         if (scl && scl_q && sda_q && !serial_control_data) begin
            bitc <= 8'h00;
         end else if (rise) begin
            bitc <= bitc + 8'(bitc != 8'hff);
            sh <= {sh[6:0], serial_control_data};
         end
         if (rise && bitc == 8'h08) begin
            mine <= (sh[7:1] == CFOG_TARGET_ADDR);
            rd <= sh[0];
         end
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   property p_addr_ack;
      rise && bitc == 8'h08 |-> serial_control_data == (sh[7:1] != CFOG_TARGET_ADDR);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
   property p_wr_ack;
      rise && mine && !rd && bitc > 8'h08 && bitc % 9 == 8 |-> !serial_control_data;
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
   property p_rd_cnt;
      rise && mine && rd && bitc == 8'h11 |-> sh == CFOG_READ_COUNT;
   endproperty
   a_rd_cnt: assert property (p_rd_cnt) else $error("read count wrong");
   property p_dev_edge;
      $changed(dev_sda_oe) |-> !scl;
   endproperty
   a_dev_edge: assert property (p_dev_edge) else $error("device moved data, clock high");
   property p_host_frame;
      scl && scl_q && $changed(serial_control_data) |-> !dev_sda_oe;
   endproperty
   a_host_frame: assert property (p_host_frame) else $error("device framed");
   property p_hi;
      !scl && scl_q |-> hi_c >= HALF;
   endproperty
   a_hi: assert property (p_hi) else $error("clock high too short");
   property p_lo;
      rise |-> lo_c >= HALF;
   endproperty
   a_lo: assert property (p_lo) else $error("clock low too short");
   property p_hold;
      $rose(dev_sda_oe) |-> ##[1:200] !dev_sda_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("device holds data");
endmodule : cfog_properties

// ### sim/tb_clock_fanout_output_gating.sv
// Purpose: Bench for host and gating device joined by the link
// Assumes: Short quarter bit; both ends on one clock
// Notes:   Read results are checked against a note queue
`timescale 1ns/1ps
module tb_clock_fanout_output_gating
   import cfog_pkg::*;
;
   localparam int QTR = 4;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        buf_in = 1'b0;
   logic        test_oe_n = 1'b1;
   logic [1:0]  avs_address = 2'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, busy, selected;
   logic [13:0] clk_out, clk_oe;
   logic [7:0]  gl, gm, gh;
   logic [7:0]  eg [3];
   logic [31:0] exp_q [$];
   string       name_q [$];
   int          bad_count = 0;
   int          n_tests = 0;

   cfog_if link_if ();
   cfog_dev cfog_dev_inst (.i_ref_clk(ref_clk), .i_rst(rst), .i_ce(1'b1), .i_buf_in(buf_in),
      .i_test_oe_n(test_oe_n), .o_clk_out(clk_out), .o_clk_oe(clk_oe), .o_gate_low(gl),
      .o_gate_mid(gm), .o_gate_high(gh), .o_selected(selected), .link(link_if));
   cfog_host #(.QTR_CYC(QTR)) cfog_host_inst (.i_ref_clk(ref_clk), .i_rst(rst), .i_ce(1'b1),
      .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest), .o_busy(busy), .link(link_if));
   cfog_properties #(.QTR(QTR)) cfog_properties_inst (.i_ref_clk(ref_clk), .i_rst(rst),
      .scl(link_if.scl), .serial_control_data(link_if.serial_control_data),
      .dev_sda_oe(link_if.dev_sda_oe));

   always #4 ref_clk = ~ref_clk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Request stands until waitrequest is seen low at a rising edge; no fixed wait assumed
   task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 99) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 99) bad_count++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic rd_exp(input logic [1:0] a, input logic [31:0] e, input string what);
      exp_q.push_back(e);
      name_q.push_back(what);
      bus(a, 1'b0, 32'h0);
   endtask : rd_exp

   // Read data is taken at the very edge that sees waitrequest low
   always @(posedge ref_clk) begin
      if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         chk(name_q.pop_front(), avs_readdata, exp_q.pop_front());
      end
   end

   task automatic xfer(input logic dir, input logic [1:0] nb, input logic [23:0] wd);
      int n;
      n = 0;
      for (int k = 0; k < 3; k++) begin
         if (!dir && k < nb) eg[k] = wd[8*k +: 8];
      end
      bus(CFOG_REG_WDATA, 1'b1, {8'h00, wd});
      bus(CFOG_REG_CTRL, 1'b1, {28'h0, nb, dir, 1'b1});
      // Ignored while busy, else later bytes go out as ones
      bus(CFOG_REG_WDATA, 1'b1, 32'h00ffffff);
      while (busy !== 1'b0 && n < 9999) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 9999) bad_count++;
      rd_exp(CFOG_REG_STATUS, 32'h0, "status");
      chk("selected", selected, 32'h0);
   endtask : xfer

   task automatic check_outs();
      logic [13:0] m;
      m = {eg[2][7:6], eg[1][7:4], eg[1][1:0], eg[0][7:6], eg[0][3:0]};
      chk("gates", {gh, gm, gl}, {eg[2], eg[1], eg[0]});
      for (int i = 0; i < 4; i++) begin
         buf_in <= i[0];
         test_oe_n <= (i != 2);
         @(negedge ref_clk);
         chk("clk_out", clk_out, {14{i[0]}} & m);
         chk("clk_oe", clk_oe, {14{i != 2}});
         @(posedge ref_clk);
      end
   endtask : check_outs

   task automatic wr_rd(input logic [1:0] nb);
      xfer(1'b0, nb, 24'($urandom) & 24'hc0f3cf);
      xfer(1'b1, 2'h3, 24'h0);
      rd_exp(CFOG_REG_RDATA, {eg[2], eg[1], eg[0], 8'h03}, "rdata");
      check_outs();
   endtask : wr_rd

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      logic [15:0] o;
      eg[0] = CFOG_GATE_LOW_RST;
      eg[1] = CFOG_GATE_MID_RST;
      eg[2] = CFOG_GATE_HIGH_RST;
      void'($urandom(32'hcc7b));
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      xfer(1'b1, 2'h3, 24'h0);
      rd_exp(CFOG_REG_RDATA, {CFOG_GATE_HIGH_RST, CFOG_GATE_MID_RST, CFOG_GATE_LOW_RST,
                              CFOG_READ_COUNT}, "rdata");
      check_outs();
      // Counts 1, 2, 3, 0, 1, 2: stop after any byte
      for (int r = 0; r < 6; r++) begin
         wr_rd(2'(r + 1));
      end
      o = {eg[2], eg[1]};
      xfer(1'b0, 2'h3, 24'($urandom) & 24'hc0f3cf);
      xfer(1'b1, 2'h1, 24'h0);
      rd_exp(CFOG_REG_RDATA, {o, eg[0], 8'h03}, "rdata");
      rd_exp(CFOG_REG_CTRL, 32'h6, "ctrl");
      check_outs();
      end_sim();
   end

   // About four and a half times the expected run
   initial begin
      #400000;
      bad_count++;
      end_sim();
   end
endmodule : tb_clock_fanout_output_gating
